// file: lio_pkg.sv
// Package for the logical input/output channel bank.
// Assumes a single 100 MHz system clock shared by all users of these types.
package lio_pkg;

  // --------------------------------------------------------------------------
  // Sizes and timing
  // --------------------------------------------------------------------------
  localparam int LIO_CHANNELS = 32;
  localparam int LIO_IDX_W = 5;
  localparam int LIO_CLK_MHZ = 100;
  localparam int LIO_PULSE_MS = 5;
  // Pulse width in cycles: 5 ms at 100 MHz = 500000
  localparam int LIO_PULSE_CYC = LIO_PULSE_MS * 1000 * LIO_CLK_MHZ;
  localparam int LIO_TS_W = 48;
  localparam int LIO_CNT_W = 20;

  // --------------------------------------------------------------------------
  // Field values
  // --------------------------------------------------------------------------
  localparam logic LIO_MODE_HOLD = 1'h0;
  localparam logic LIO_MODE_PULSE = 1'h1;
  localparam logic LIO_BANK_OUT = 1'h0;
  localparam logic LIO_BANK_IN = 1'h1;
  localparam logic [1:0] LIO_SEL_BOTH = 2'h0;
  localparam logic [1:0] LIO_SEL_ON = 2'h1;
  localparam logic [1:0] LIO_SEL_OFF = 2'h2;
  localparam logic [31:0] LIO_RST_BANK = 32'h0000_0000;

  // Command to one logical input
  typedef struct packed {
    logic valid;
    logic [LIO_IDX_W-1:0] chan;
    logic value;
  } lio_cmd_t;

  // One event record
  typedef struct packed {
    logic valid;
    logic bank;
    logic [LIO_IDX_W-1:0] chan;
    logic on;
    logic [LIO_TS_W-1:0] stamp;
  } lio_event_t;

endpackage : lio_pkg

// file: lio_channels.sv
// Logical input/output channel bank with event generation.
// Assumes commands and user logic come from logic on the same clock.
`timescale 1ns/10ps

// Operation
// - Thirty-two logical outputs each carry one user-logic bit out.
// - Thirty-two logical inputs can be set or cleared by a local or remote command.
// - All logical inputs come up at zero after every reset.
// - A latched input set to one stays one until commanded to zero or reset.
// - A single-pulse input set to one falls back to zero 5 ms later on its own.
// - Each input is configured as latched or single-pulse, nothing else.
// - Every status change gives an ON or OFF event with channel index and bank, unless the channel changes again before that event is scanned.
// - A selection keeps ON only, OFF only or both events; others are dropped.
// - Each event carries a time stamp taken when the change happened.
module lio_channels
  import lio_pkg::*;
#(
  parameter int PULSE_CYC = LIO_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire lio_cmd_t local_cmd,
  input wire lio_cmd_t remote_cmd,
  input wire logic [LIO_CHANNELS-1:0] input_mode,
  input wire logic [LIO_CHANNELS-1:0] user_logic,
  input wire logic [1:0] event_sel,
  output logic [LIO_CHANNELS-1:0] logical_in,
  output logic [LIO_CHANNELS-1:0] logical_out,
  output lio_event_t event_out,
  output logic event_drop
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  // Events are scanned one per cycle from pending bits. A bank can change all 32
  // channels in one cycle, so under bursts the pending sets fill faster than the
  // single scan drains them; a change that lands on a still-pending bit of the
  // opposite polarity is reported in event_drop rather than lost silently.
  typedef struct packed {
    logic [LIO_CHANNELS-1:0] in_st;
    logic [LIO_CHANNELS-1:0] out_st;
    logic [LIO_CHANNELS-1:0][LIO_CNT_W-1:0] cnt;
    logic [LIO_CHANNELS-1:0] pend_in;
    logic [LIO_CHANNELS-1:0] pend_out;
    logic [LIO_CHANNELS-1:0] pol_in;
    logic [LIO_CHANNELS-1:0] pol_out;
    logic [LIO_CHANNELS-1:0][LIO_TS_W-1:0] ts_in;
    logic [LIO_CHANNELS-1:0][LIO_TS_W-1:0] ts_out;
    logic [LIO_TS_W-1:0] now;
    lio_event_t ev;
    logic drop;
  } lio_state_t;

  lio_state_t s_q;
  lio_state_t s_d;

  localparam logic [LIO_CNT_W-1:0] PULSE_LOAD = LIO_CNT_W'(PULSE_CYC);

  function automatic logic keep_pol(input logic [1:0] sel, input logic on);
    keep_pol = (sel == LIO_SEL_BOTH) || (sel == LIO_SEL_ON && on) ||
               (sel == LIO_SEL_OFF && !on);
  endfunction : keep_pol

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [LIO_CHANNELS-1:0] nin;
    logic found;
    s_d = s_q;
    nin = s_q.in_st;
    found = 1'b0;
    s_d.now = s_q.now + LIO_TS_W'(1);
    s_d.ev = '0;
    s_d.drop = 1'b0;
    for (int i = 0; i < LIO_CHANNELS; i++) begin
      // Pulse expiry
      if (input_mode[i] == LIO_MODE_PULSE && s_q.in_st[i]) begin
        if (s_q.cnt[i] <= LIO_CNT_W'(1)) begin
          nin[i] = 1'b0;
        end
        s_d.cnt[i] = s_q.cnt[i] - LIO_CNT_W'(1);
      end
      if (input_mode[i] == LIO_MODE_HOLD) begin
        s_d.cnt[i] = '0;
      end
      // Remote applied first so that a local command in the same cycle wins
      for (int k = 0; k < 2; k++) begin
        lio_cmd_t c;
        c = (k == 0) ? remote_cmd : local_cmd;
        if (c.valid && c.chan == LIO_IDX_W'(i)) begin
          nin[i] = c.value;
          if (c.value && input_mode[i] == LIO_MODE_PULSE) begin
            s_d.cnt[i] = PULSE_LOAD;
          end
        end
      end
    end
    s_d.in_st = nin;
    s_d.out_st = user_logic;
    // Scan one pending event, input bank first
    for (int i = 0; i < LIO_CHANNELS; i++) begin
      if (!found && s_q.pend_in[i]) begin
        found = 1'b1;
        s_d.pend_in[i] = 1'b0;
        s_d.ev = '{valid: keep_pol(event_sel, s_q.pol_in[i]), bank: LIO_BANK_IN,
                   chan: LIO_IDX_W'(i), on: s_q.pol_in[i], stamp: s_q.ts_in[i]};
      end
    end
    for (int i = 0; i < LIO_CHANNELS; i++) begin
      if (!found && s_q.pend_out[i]) begin
        found = 1'b1;
        s_d.pend_out[i] = 1'b0;
        s_d.ev = '{valid: keep_pol(event_sel, s_q.pol_out[i]), bank: LIO_BANK_OUT,
                   chan: LIO_IDX_W'(i), on: s_q.pol_out[i], stamp: s_q.ts_out[i]};
      end
    end
    // Capture new changes; a new change wins over the clear of its pending bit
    for (int i = 0; i < LIO_CHANNELS; i++) begin
      if (nin[i] != s_q.in_st[i]) begin
        if (s_q.pend_in[i] && s_d.pend_in[i]) begin
          s_d.drop = 1'b1;
        end
        s_d.pend_in[i] = 1'b1;
        s_d.pol_in[i] = nin[i];
        s_d.ts_in[i] = s_q.now;
      end
      if (user_logic[i] != s_q.out_st[i]) begin
        if (s_q.pend_out[i] && s_d.pend_out[i]) begin
          s_d.drop = 1'b1;
        end
        s_d.pend_out[i] = 1'b1;
        s_d.pol_out[i] = user_logic[i];
        s_d.ts_out[i] = s_q.now;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign logical_in = s_q.in_st;
  assign logical_out = s_q.out_st;
  assign event_out = s_q.ev;
  assign event_drop = s_q.drop;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence set_cmd0;
    local_cmd.valid && local_cmd.chan == 5'h0 && local_cmd.value &&
    !(remote_cmd.valid && remote_cmd.chan == 5'h0);
  endsequence

  a_out_follow: assert property (logical_out == $past(user_logic))
    else $error("logical output not following user logic");
  a_hold_set: assert property (set_cmd0 ##0 input_mode[0] == LIO_MODE_HOLD
                               |=> logical_in[0])
    else $error("latched input did not set");
  a_hold_keep: assert property (logical_in[0] && input_mode[0] == LIO_MODE_HOLD &&
      !(local_cmd.valid && local_cmd.chan == 5'h0) &&
      !(remote_cmd.valid && remote_cmd.chan == 5'h0) |=> logical_in[0])
    else $error("latched input dropped on its own");
  a_pulse_set: assert property (set_cmd0 ##0 input_mode[0] == LIO_MODE_PULSE
                                |=> logical_in[0] && s_q.cnt[0] == PULSE_LOAD)
    else $error("pulse timer not loaded");
  a_pulse_end: assert property (logical_in[0] && input_mode[0] == LIO_MODE_PULSE &&
      s_q.cnt[0] == 20'h1 && !(local_cmd.valid && local_cmd.chan == 5'h0) &&
      !(remote_cmd.valid && remote_cmd.chan == 5'h0) |=> !logical_in[0])
    else $error("pulse did not end");
  a_in_event: assert property ($rose(logical_in[1]) |-> s_q.pend_in[1] && s_q.pol_in[1])
    else $error("input change not recorded");
  a_ev_filter: assert property (event_out.valid && event_sel == LIO_SEL_ON
                                |-> event_out.on || $changed(event_sel))
    else $error("unselected polarity emitted");
  a_ev_stamp: assert property ($changed(user_logic[2]) && !s_q.pend_out[2]
                               |=> s_q.ts_out[2] == $past(s_q.now))
    else $error("time stamp not captured");

endmodule : lio_channels

// file: lio_far_side.sv
// User logic beside the channel bank: passes bench levels to the outputs.
// Assumes the bank's clock and reset; bit 0 stretches the input 0 pulse.
`timescale 1ns/10ps
module lio_far_side
  import lio_pkg::*;
#(
  parameter int STRETCH = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [LIO_CHANNELS-1:0] ext_logic,
  input wire logic pulse_in,
  output logic [LIO_CHANNELS-1:0] user_logic
);
  // ---------------------------------------------------------------------------
  // Falling-edge delay on channel 0
  // ---------------------------------------------------------------------------
  int cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
    end else if (pulse_in) begin
      cnt_q <= STRETCH;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign user_logic = {ext_logic[LIO_CHANNELS-1:1], pulse_in | (cnt_q != 0)};
endmodule : lio_far_side

// file: logical_io_channels_tb_top.sv
// Self-checking bench for the logical channel bank.
// Assumes a short pulse parameter so single-pulse timing fits the run.
`timescale 1ns/10ps
module logical_io_channels_tb_top;
  import lio_pkg::*;
  localparam int P = 20;
  logic clk = 0, rst = 1;
  lio_cmd_t lc = '0, rc = '0;
  logic [31:0] mode = '0, ext = '0, ul, li, lo;
  logic [1:0] sel = LIO_SEL_BOTH;
  lio_event_t ev_o;
  int bad_count = 0, comparisons = 0;
  int drops = 0;
  logic drop;
  lio_channels #(.PULSE_CYC(P)) dut_u (.clk(clk), .rst(rst), .local_cmd(lc), .remote_cmd(rc),
    .input_mode(mode), .user_logic(ul), .event_sel(sel), .logical_in(li), .logical_out(lo),
    .event_out(ev_o), .event_drop(drop));
  lio_far_side far_u (.clk(clk), .rst(rst), .ext_logic(ext), .pulse_in(li[0]), .user_logic(ul));
  initial begin
    forever #5 clk = ~clk;
  end
  // No scenario outruns the scan, so any overwrite is a fault
  always @(posedge clk) begin
    if (drop === 1'b1) drops++;
  end
  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task cmd(input logic remote, input logic [4:0] c, input logic v);
    @(negedge clk);
    if (remote) rc = '{1'b1, c, v};
    else lc = '{1'b1, c, v};
    @(negedge clk);
    lc = '0;
    rc = '0;
  endtask : cmd
  // Waits a bounded span; an event that is not expected must not show either
  task ev(input logic e, input logic b, input logic [4:0] c, input logic o);
    logic got;
    got = 0;
    repeat (8) @(negedge clk) begin
      if (ev_o.valid === 1'b1 && !got) begin
        got = 1;
        chk({ev_o.bank, ev_o.chan, ev_o.on}, {b, c, o});
      end
    end
    chk(got, e);
  endtask : ev
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    chk(li, 32'h0000_0000);
    chk(lo, 32'h0000_0000);
    $display("reset test done");
    cmd(0, 5'h03, 1);
    ev(1, LIO_BANK_IN, 5'h03, 1);
    chk(li, 32'h0000_0008);
    cmd(1, 5'h03, 0);
    ev(1, LIO_BANK_IN, 5'h03, 0);
    chk(li, 32'h0000_0000);
    $display("latched test done");
    sel = LIO_SEL_ON;
    ext[7] = 1;
    @(negedge clk);
    chk(lo, 32'h0000_0080);
    ev(1, LIO_BANK_OUT, 5'h07, 1);
    ext[7] = 0;
    ev(0, 0, 0, 0);
    sel = LIO_SEL_OFF;
    ext[31] = 1;
    ev(0, 0, 0, 0);
    ext[31] = 0;
    ev(1, LIO_BANK_OUT, 5'h1F, 0);
    $display("event test done");
    mode[5] = LIO_MODE_PULSE;
    cmd(0, 5'h05, 1);
    repeat (12) @(negedge clk);
    chk(li, 32'h0000_0020);
    cmd(1, 5'h05, 1);
    repeat (12) @(negedge clk);
    chk(li, 32'h0000_0020);
    repeat (10) @(negedge clk);
    chk(li, 32'h0000_0000);
    $display("pulse test done");
    mode[0] = LIO_MODE_PULSE;
    cmd(0, 5'h00, 1);
    repeat (28) @(negedge clk);
    chk(li, 32'h0000_0000);
    chk(lo, 32'h0000_0001);
    repeat (40) @(negedge clk);
    chk(lo, 32'h0000_0000);
    chk(drops, 0);
    $display("stretch test done");
    stop_test();
  end
endmodule : logical_io_channels_tb_top
